// file: shared/bcq_pkg.sv
// constants and types shared by the bus cache event qualifier
package bcq_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_SEL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_CNT = 8'h08;

  // event selection register fields
  localparam int SEL_EN_BIT    = 0;
  localparam int SEL_MASK_LSB  = 9;
  localparam int SEL_MASK_MSB  = 24;
  localparam int SEL_CODE_LSB  = 25;
  localparam int SEL_CODE_MSB  = 31;

  // counter configuration register fields
  localparam int CFG_EN_BIT    = 12;
  localparam int CFG_SEL_LSB   = 13;
  localparam int CFG_SEL_MSB   = 15;

  // reset values
  localparam logic [6:0]  CODE_RST  = 7'h00;
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [2:0]  CSEL_RST  = 3'h0;
  localparam logic [31:0] CNT_RST   = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // event codes and counter group selects
  localparam logic [6:0] EVT_CACHE_REF   = 7'h0C;
  localparam logic [6:0] EVT_QUEUE_ALLOC = 7'h03;
  localparam logic [2:0] CSEL_CACHE_REF  = 3'h7;
  localparam logic [2:0] CSEL_QUEUE      = 3'h6;

  // cache reference mask bits
  localparam int CR_L2_HITS  = 0;
  localparam int CR_L2_HITE  = 1;
  localparam int CR_L2_HITM  = 2;
  localparam int CR_L3_HITS  = 3;
  localparam int CR_L3_HITE  = 4;
  localparam int CR_L3_HITM  = 5;
  localparam int CR_L2_MISS  = 8;
  localparam int CR_L3_MISS  = 9;
  localparam int CR_WB_MISS  = 10;

  // queue allocation mask fields
  localparam int QA_REQ_LSB  = 0;
  localparam int QA_REQ_W    = 5;
  localparam int QA_ALL_RD   = 5;
  localparam int QA_ALL_WR   = 6;
  localparam int QA_MEM_LSB  = 7;
  localparam int QA_MEM_W    = 2;
  localparam int QA_AGT_LSB  = 13;
  localparam int QA_AGT_W    = 2;
  localparam int QA_PREFETCH = 15;

  // line state as reported by a cache lookup
  typedef enum logic [1:0] {
    BCQ_INV = 2'b00,
    BCQ_SHR = 2'b01,
    BCQ_EXC = 2'b10,
    BCQ_MOD = 2'b11
  } bcq_line_t;

  // register access sequencing
  typedef enum logic [1:0] {
    BCQ_IDLE = 2'b00,
    BCQ_RESP = 2'b01
  } bcq_apb_st_t;

endpackage : bcq_pkg

// file: hdl/bcq_field_match.sv
// one mask field compared against the matching transaction attribute
`timescale 1ns/1ps

module bcq_field_match #(
  parameter int W = 2
) (
  input  wire logic [W-1:0] mask,
  input  wire logic [W-1:0] value,
  output logic              hit
);

  logic [W-1:0] sel_v;

  // each set mask bit admits the value that bit stands for
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      assign sel_v[i] = mask[i] & value[i];
    end
  endgenerate

  assign hit = |sel_v;

endmodule : bcq_field_match

// file: hdl/bcq_qualifier.sv
// bus cache reference and queue allocation event qualifier with apb registers
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// - mask bit 2 counts reads hitting the l2 in modified state.
// - mask bits 3-5 count reads hitting l3 shared, exclusive, modified.
// - bit 8 counts l2 read misses, bit 9 counts l3 read misses.
// - bit 10 counts writeback lookups missing the l2; rare.
// - loads and ownership requests both count as reads.
// - prefetch and hit status are taken as finally reported.
// - one count per matching allocation into the in-order bus queue.
// - sector or chunk allocations count once each.
// - every retry of a request counts again.
// - bits 0-4 are the request type field; set bits select values.
// - bits 7 and 8 select the target memory type.
// - bits 13 and 14 select the source agent.
// - bit 15 affects reads only, never writes.
// - ((type or bit5 or bit6) or memtype) and agent.
// - software sets mask bits; write type is writebacks and evictions.
module bcq_qualifier #(
  parameter int AW = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic          cr_valid,
  input  wire logic          cr_load,
  input  wire logic          cr_rfo,
  input  wire logic          cr_write,
  input  wire logic [1:0]    cr_l2_state,
  input  wire logic          cr_l3_valid,
  input  wire logic [1:0]    cr_l3_state,
  input  wire logic          qa_valid,
  input  wire logic [4:0]    qa_req_type,
  input  wire logic          qa_read,
  input  wire logic          qa_write,
  input  wire logic          qa_prefetch,
  input  wire logic [1:0]    qa_mem_type,
  input  wire logic [1:0]    qa_agent,
  output logic               evt_pulse,
  output logic [31:0]        evt_count
);

  typedef struct packed {
    bcq_pkg::bcq_apb_st_t apb_st;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    logic [6:0]           evt_code;
    logic [15:0]          evt_mask;
    logic                 sel_en;
    logic [2:0]           cfg_sel;
    logic                 cfg_en;
    logic [31:0]          count;
    logic                 pulse;
  } bcq_state_t;

  bcq_state_t s_q;
  bcq_state_t s_d;

  logic [15:0] cr_ev;
  logic        cr_rd;
  logic        cr_hit;
  logic        req_hit;
  logic        mem_hit;
  logic        agt_hit;
  logic        pref_ok;
  logic        qa_hit;
  logic        cr_armed;
  logic        qa_armed;
  logic        fire;
  logic        l2_miss;
  logic        l3_miss;
  logic [7:0]  addr8;
  logic        map_hit;
  logic [31:0] sel_word;
  logic [31:0] cfg_word;
  logic [31:0] rd_word;

  bcq_field_match #(
    .W (bcq_pkg::QA_REQ_W)
  ) u_req (
    .mask  (s_q.evt_mask[bcq_pkg::QA_REQ_LSB +: bcq_pkg::QA_REQ_W]),
    .value (qa_req_type),
    .hit   (req_hit)
  );

  bcq_field_match #(
    .W (bcq_pkg::QA_MEM_W)
  ) u_mem (
    .mask  (s_q.evt_mask[bcq_pkg::QA_MEM_LSB +: bcq_pkg::QA_MEM_W]),
    .value (qa_mem_type),
    .hit   (mem_hit)
  );

  bcq_field_match #(
    .W (bcq_pkg::QA_AGT_W)
  ) u_agt (
    .mask  (s_q.evt_mask[bcq_pkg::QA_AGT_LSB +: bcq_pkg::QA_AGT_W]),
    .value (qa_agent),
    .hit   (agt_hit)
  );

  // register views
  always_comb
  begin
    sel_word = 32'h0000_0000;
    sel_word[bcq_pkg::SEL_CODE_MSB:bcq_pkg::SEL_CODE_LSB] = s_q.evt_code;
    sel_word[bcq_pkg::SEL_MASK_MSB:bcq_pkg::SEL_MASK_LSB] = s_q.evt_mask;
    sel_word[bcq_pkg::SEL_EN_BIT] = s_q.sel_en;
    cfg_word = 32'h0000_0000;
    cfg_word[bcq_pkg::CFG_SEL_MSB:bcq_pkg::CFG_SEL_LSB] = s_q.cfg_sel;
    cfg_word[bcq_pkg::CFG_EN_BIT] = s_q.cfg_en;
  end

  // address decode, upper address bits must be zero
  always_comb
  begin
    addr8   = paddr[7:0];
    map_hit = 1'b0;
    rd_word = 32'h0000_0000;
    if ((paddr >> 8) == '0)
    begin
      case (addr8)
        bcq_pkg::OFS_SEL:
        begin
          map_hit = 1'b1;
          rd_word = sel_word;
        end
        bcq_pkg::OFS_CFG:
        begin
          map_hit = 1'b1;
          rd_word = cfg_word;
        end
        bcq_pkg::OFS_CNT:
        begin
          map_hit = 1'b1;
          rd_word = s_q.count;
        end
        default:
        begin
          map_hit = 1'b0;
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // cache reference qualification
  always_comb
  begin
    cr_rd   = cr_load | cr_rfo;
    l2_miss = (cr_l2_state == bcq_pkg::BCQ_INV);
    l3_miss = cr_l3_valid && (cr_l3_state == bcq_pkg::BCQ_INV);
    cr_ev   = 16'h0000;
    cr_ev[bcq_pkg::CR_L2_HITS] = cr_rd && (cr_l2_state == bcq_pkg::BCQ_SHR);
    cr_ev[bcq_pkg::CR_L2_HITE] = cr_rd && (cr_l2_state == bcq_pkg::BCQ_EXC);
    cr_ev[bcq_pkg::CR_L2_HITM] = cr_rd && (cr_l2_state == bcq_pkg::BCQ_MOD);
    cr_ev[bcq_pkg::CR_L3_HITS] = cr_rd && cr_l3_valid
                                 && (cr_l3_state == bcq_pkg::BCQ_SHR);
    cr_ev[bcq_pkg::CR_L3_HITE] = cr_rd && cr_l3_valid
                                 && (cr_l3_state == bcq_pkg::BCQ_EXC);
    cr_ev[bcq_pkg::CR_L3_HITM] = cr_rd && cr_l3_valid
                                 && (cr_l3_state == bcq_pkg::BCQ_MOD);
    cr_ev[bcq_pkg::CR_L2_MISS] = cr_rd && l2_miss;
    cr_ev[bcq_pkg::CR_L3_MISS] = cr_rd && l3_miss;
    // write type is writeback or eviction
    cr_ev[bcq_pkg::CR_WB_MISS] = cr_write && l2_miss;
    // final hit state
    // states are sampled as reported in the lookup cycle, so a late
    // reclassification is seen as its final value, never twice
    cr_hit = cr_valid && |(cr_ev & s_q.evt_mask);
  end

  // queue allocation qualification
  always_comb
  begin
    pref_ok = !(qa_read && qa_prefetch) || s_q.evt_mask[bcq_pkg::QA_PREFETCH];
    qa_hit  = ((req_hit
                || (s_q.evt_mask[bcq_pkg::QA_ALL_RD] && qa_read)
                || (s_q.evt_mask[bcq_pkg::QA_ALL_WR] && qa_write))
               || mem_hit) && agt_hit;
    qa_hit  = qa_valid && pref_ok && qa_hit;
  end

  always_comb
  begin
    cr_armed = (s_q.evt_code == bcq_pkg::EVT_CACHE_REF)
               && (s_q.cfg_sel == bcq_pkg::CSEL_CACHE_REF);
    qa_armed = (s_q.evt_code == bcq_pkg::EVT_QUEUE_ALLOC)
               && (s_q.cfg_sel == bcq_pkg::CSEL_QUEUE);
    // codes are exclusive, so two sources never stack into one cycle
    fire     = s_q.sel_en && s_q.cfg_en
               && ((cr_armed && cr_hit) || (qa_armed && qa_hit));
  end

  // next state
  always_comb
  begin
    s_d       = s_q;
    s_d.pulse = fire;
    if (fire)
    begin
      s_d.count = s_q.count + 32'h0000_0001;
    end
    case (s_q.apb_st)
      bcq_pkg::BCQ_IDLE:
      begin
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && penable)
        begin
          // one wait state keeps pready and prdata straight from flops
          s_d.apb_st  = bcq_pkg::BCQ_RESP;
          s_d.pready  = 1'b1;
          s_d.pslverr = !map_hit;
          s_d.prdata  = pwrite ? 32'h0000_0000 : rd_word;
        end
      end
      bcq_pkg::BCQ_RESP:
      begin
        s_d.apb_st  = bcq_pkg::BCQ_IDLE;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && penable && pwrite && map_hit)
        begin
          case (addr8)
            bcq_pkg::OFS_SEL:
            begin
              if (pstrb[3])
              begin
                s_d.evt_code = pwdata[bcq_pkg::SEL_CODE_MSB:bcq_pkg::SEL_CODE_LSB];
                s_d.evt_mask[15] = pwdata[bcq_pkg::SEL_MASK_MSB];
              end
              if (pstrb[2])
              begin
                s_d.evt_mask[14:7] = pwdata[23:16];
              end
              if (pstrb[1])
              begin
                s_d.evt_mask[6:0] = pwdata[15:9];
              end
              if (pstrb[0])
              begin
                s_d.sel_en = pwdata[bcq_pkg::SEL_EN_BIT];
              end
            end
            bcq_pkg::OFS_CFG:
            begin
              if (pstrb[1])
              begin
                s_d.cfg_sel = pwdata[bcq_pkg::CFG_SEL_MSB:bcq_pkg::CFG_SEL_LSB];
                s_d.cfg_en  = pwdata[bcq_pkg::CFG_EN_BIT];
              end
            end
            bcq_pkg::OFS_CNT:
            begin
              // a clear with an event in the same cycle leaves the count at 1
              s_d.count = fire ? 32'h0000_0001 : bcq_pkg::CNT_RST;
            end
            default:
            begin
              s_d.count = s_d.count;
            end
          endcase
        end
      end
      default:
      begin
        s_d.apb_st = bcq_pkg::BCQ_IDLE;
        s_d.pready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.apb_st   <= bcq_pkg::BCQ_IDLE;
      s_q.pready   <= 1'b0;
      s_q.prdata   <= bcq_pkg::RDATA_RST;
      s_q.pslverr  <= 1'b0;
      s_q.evt_code <= bcq_pkg::CODE_RST;
      s_q.evt_mask <= bcq_pkg::MASK_RST;
      s_q.sel_en   <= 1'b0;
      s_q.cfg_sel  <= bcq_pkg::CSEL_RST;
      s_q.cfg_en   <= 1'b0;
      s_q.count    <= bcq_pkg::CNT_RST;
      s_q.pulse    <= 1'b0;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign pready    = s_q.pready;
  assign prdata    = s_q.prdata;
  assign pslverr   = s_q.pslverr;
  assign evt_pulse = s_q.pulse;
  assign evt_count = s_q.count;

endmodule : bcq_qualifier

// file: tb/bcq_bus_src.sv
// far-side model: cache lookups and queue allocations
`timescale 1ns/1ps

module bcq_bus_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] rnd,
  output logic             cr_valid,
  output logic             cr_load,
  output logic             cr_rfo,
  output logic             cr_write,
  output logic [1:0]       cr_l2_state,
  output logic             cr_l3_valid,
  output logic [1:0]       cr_l3_state,
  output logic             qa_valid,
  output logic [4:0]       qa_req_type,
  output logic             qa_read,
  output logic             qa_write,
  output logic             qa_prefetch,
  output logic [1:0]       qa_mem_type,
  output logic [1:0]       qa_agent
);
  // back-to-back valids stand in for retries
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {cr_valid, cr_load, cr_rfo, cr_write, cr_l2_state, cr_l3_valid, cr_l3_state} <= '0;
      {qa_valid, qa_req_type, qa_read, qa_write, qa_prefetch, qa_mem_type, qa_agent} <= '0;
    end
    else
    begin
      {cr_load, cr_rfo, cr_write} <= 3'h4 >> rnd[2:1];
      {cr_valid, cr_l2_state, cr_l3_valid, cr_l3_state} <= {rnd[0], rnd[7:3]};
      {qa_valid, qa_req_type, qa_prefetch, qa_mem_type, qa_agent} <= rnd[18:8];
      qa_read  <= rnd[19];
      qa_write <= !rnd[19];
    end
endmodule : bcq_bus_src

// file: tb/bcq_qualifier_assertions.sv
// assertion checker for the event qualifier ports
`timescale 1ns/1ps

module bcq_chk #(
  parameter int AW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          clk_en,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [3:0]    pstrb,
  input wire logic          pready,
  input wire logic          cr_valid,
  input wire logic          cr_load,
  input wire logic          cr_rfo,
  input wire logic          cr_write,
  input wire logic [1:0]    cr_l2_state,
  input wire logic [1:0]    qa_agent,
  input wire logic          evt_pulse,
  input wire logic [31:0]   evt_count
);
  logic [6:0]  code_q;
  logic [15:0] mask_q;
  logic [2:0]  csel_q;
  logic        sen_q, cen_q, ok_q, wr, clr, rd, cm, qm;
  // a frozen edge moves no design state, so it proves nothing
  assign wr  = clk_en && psel && penable && pready && pwrite;
  assign clr = wr && paddr == AW'(bcq_pkg::OFS_CNT);
  assign rd  = cr_valid && (cr_load || cr_rfo);
  assign cm  = clk_en && ok_q && sen_q && cen_q && code_q == 7'h0C && csel_q == 3'h7;
  assign qm  = clk_en && ok_q && sen_q && cen_q && code_q == 7'h03 && csel_q == 3'h6;
  // shadow only full-word writes; partial strobes void it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {code_q, mask_q, csel_q, sen_q, cen_q, ok_q} <= 29'h1;
    else if (wr && pstrb != 4'hF)
      ok_q <= 1'h0;
    else if (wr && paddr == AW'(bcq_pkg::OFS_SEL))
      {code_q, mask_q, sen_q} <= {pwdata[31:9], pwdata[0]};
    else if (wr && paddr == AW'(bcq_pkg::OFS_CFG))
      {csel_q, cen_q} <= pwdata[15:12];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  AST_APB_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("apb answer late");
  AST_L2_HITM: assert property (
    cm && rd && cr_l2_state == 2'h3 && mask_q[2] |=> evt_pulse)
    else $error("l2 modified read not counted");
  AST_L2_MISS: assert property (
    cm && rd && cr_l2_state == 2'h0 && mask_q[8] |=> evt_pulse)
    else $error("l2 read miss not counted");
  AST_WB_MISS: assert property (
    cm && cr_valid && cr_write && cr_l2_state == 2'h0 && mask_q[10] |=> evt_pulse)
    else $error("writeback miss not counted");
  AST_QA_AGENT: assert property (
    qm && (mask_q[14:13] & qa_agent) == 2'h0 |=> !evt_pulse)
    else $error("agent mismatch counted");
  AST_IDLE_CODE: assert property (clk_en && ok_q && !cm && !qm |=> !evt_pulse)
    else $error("pulse without selection");
  AST_COUNT_STEP: assert property (
    $past(clk_en) && evt_pulse && !$past(clr) |-> evt_count == $past(evt_count) + 32'h1)
    else $error("count not stepped by pulse");
  AST_COUNT_HOLD: assert property (
    $past(clk_en) && !evt_pulse && !$past(clr) |-> $stable(evt_count))
    else $error("count moved without pulse");
endmodule : bcq_chk

bind bcq_qualifier bcq_chk #(.AW(AW)) i_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .cr_valid, .cr_load, .cr_rfo, .cr_write, .cr_l2_state,
  .qa_agent, .evt_pulse, .evt_count);

// file: tb/bcq_qualifier_tb.sv
// self-checking bench for the event qualifier
`timescale 1ns/1ps

module bcq_qualifier_tb;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, evt_pulse;
  logic        cr_valid, cr_load, cr_rfo, cr_write, cr_l3_valid, qa_valid, qa_read;
  logic        qa_write, qa_prefetch, se, ce, ep, ch, qh, rd, er;
  logic [1:0]  cr_l2_state, cr_l3_state, qa_mem_type, qa_agent;
  logic [4:0]  qa_req_type;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, evt_count, rnd, mc, rv;
  logic [15:0] m, mm;
  logic [6:0]  cd;
  logic [2:0]  cs;
  int          mismatches, tests_run;
  int          seed = 76747;
  int          bits[9] = '{0, 1, 2, 3, 4, 5, 8, 9, 10};

  bcq_bus_src i_src (.pclk, .presetn, .rnd, .cr_valid, .cr_load, .cr_rfo, .cr_write,
    .cr_l2_state, .cr_l3_valid, .cr_l3_state, .qa_valid, .qa_req_type, .qa_read, .qa_write,
    .qa_prefetch, .qa_mem_type, .qa_agent);
  bcq_qualifier #(.AW(8)) i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .cr_valid, .cr_load, .cr_rfo, .cr_write,
    .cr_l2_state, .cr_l3_valid, .cr_l3_state, .qa_valid, .qa_req_type, .qa_read, .qa_write,
    .qa_prefetch, .qa_mem_type, .qa_agent, .evt_pulse, .evt_count);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1);
    chk("apb_wait", 32'h2, n); // one wait state
    r = prdata;
    e = pslverr;
    penable <= 1'h0;
  endtask : apb

  task automatic setup(input logic [6:0] c, input logic [2:0] s, input logic [15:0] k);
    logic [31:0] r;
    logic        e;
    apb(1'h1, 8'h00, {c, k, 8'h00, 1'h1}, r, e);
    apb(1'h1, 8'h04, {16'h0, s, 1'h1, 12'h0}, r, e);
    apb(1'h1, 8'h08, 32'h0, r, e);
    apb(1'h0, 8'h00, 32'h0, r, e);
    chk("sel", {c, k, 8'h00, 1'h1}, r); // mask readback
    psel <= 1'h0;
    @(posedge pclk);
  endtask : setup

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // reference model; config written at an edge applies from the next
  always @(posedge pclk)
    if (!presetn)
      {cd, m, cs, se, ce, ep, mc} = '0;
    else
    begin
      chk("evt_pulse", {31'h0, ep}, {31'h0, evt_pulse}); // one per event
      chk("evt_count", mc, evt_count); // each counted
      // a frozen edge moves nothing in the design, so the model skips it
      if (clk_en)
      begin
        rd = cr_load | cr_rfo;
        ch = cr_valid && ((rd && cr_l2_state != 2'h0 && m[cr_l2_state - 1])
          || (rd && cr_l3_valid && cr_l3_state != 2'h0 && m[cr_l3_state + 2])
          || (rd && cr_l2_state == 2'h0 && m[8])
          || (rd && cr_l3_valid && cr_l3_state == 2'h0 && m[9])
          || (cr_write && cr_l2_state == 2'h0 && m[10]));
        qh = qa_valid && ((|(m[4:0] & qa_req_type)) || (m[5] && qa_read)
          || (m[6] && qa_write) || (|(m[8:7] & qa_mem_type))) && (|(m[14:13] & qa_agent))
          && !(qa_read && qa_prefetch && !m[15]);
        ep = se && ce && ((cd == 7'h0C && cs == 3'h7 && ch)
          || (cd == 7'h03 && cs == 3'h6 && qh));
        rd = psel && penable && pready && pwrite;
        mc = (rd && paddr == 8'h08) ? {31'h0, ep} : mc + ep;
        // byte lanes gate the selection fields
        if (rd && paddr == 8'h00)
        begin
          if (pstrb[3])
            {cd, m[15]} = pwdata[31:24];
          if (pstrb[2])
            m[14:7] = pwdata[23:16];
          if (pstrb[1])
            m[6:0] = pwdata[15:9];
          if (pstrb[0])
            se = pwdata[0];
        end
        if (rd && paddr == 8'h04 && pstrb[1])
          {cs, ce} = pwdata[15:12];
      end
    end

  always @(posedge pclk)
    rnd <= xs();

  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // some 4500 cycles expected; eleven times that allowed
  initial
  begin
    #500000;
    mismatches++;
    results();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'h1;
    pstrb = 4'hF;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 8'h00, 32'h0, rv, er);
    chk("sel_rst", 32'h0, rv); // cleared selection
    apb(1'h1, 8'h0C, 32'hFFFFFFFF, rv, er);
    chk("unmapped", 32'h1, {31'h0, er}); // refused place
    psel <= 1'h0;
    @(posedge pclk);
    for (int i = 0; i < 14; i++)
    begin
      mm = xs();
      if (i == 9)
        mm[14:13] = 2'h3;
      if (i < 9)
        setup(7'h0C, 3'h7, 16'h0001 << bits[i]); // cache bits
      else if (i < 13)
        setup(7'h03, 3'h6, mm); // queue fields
      else
        setup(7'h0C, 3'h6, mm); // wrong select
      // random freezes while events keep arriving
      repeat (299)
      begin
        @(posedge pclk);
        clk_en <= |rnd[21:20];
      end
      @(posedge pclk);
      clk_en <= 1'h1;
    end
    // a partial write touches only its own lanes
    pstrb <= 4'h1;
    apb(1'h1, 8'h00, 32'h0, rv, er);
    pstrb <= 4'hF;
    apb(1'h0, 8'h00, 32'h0, rv, er);
    chk("lane", {7'h0C, mm, 8'h00, 1'h0}, rv); // enable lane only
    psel <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 8'h00, 32'h0, rv, er);
    chk("sel_rst2", 32'h0, rv); // second reset
    psel <= 1'h0;
    repeat (50) @(posedge pclk);
    results();
  end
endmodule : bcq_qualifier_tb
